// ==== hdl/qpic_pkg.sv ====
/*
 * constants and types shared by the quadrature position init control block:
 * register offsets, field positions, reset values and mode encodings.
 * assumes a 32-bit apb slave with byte addresses in the low 8 bits.
 */
package qpic_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IOC = 8'h04;
    localparam logic [7:0] OFS_POS = 8'h08;
    localparam logic [7:0] OFS_IDXCNT = 8'h0c;
    localparam logic [7:0] OFS_HIGH = 8'h10;
    localparam logic [7:0] OFS_LOW = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_EN_BIT = 15;
    localparam int CTRL_IDLE_BIT = 13;
    localparam int CTRL_PIM_LSB = 10;
    localparam int CTRL_IMV_LSB = 8;
    localparam int CTRL_DIV_LSB = 4;
    localparam int CTRL_POL_BIT = 3;
    localparam int CTRL_GATE_BIT = 2;
    localparam int CTRL_CCM_LSB = 0;
    localparam int IOC_SWAP_BIT = 8;
    localparam int IOC_HOME_INV_BIT = 7;
    localparam int IOC_IDX_INV_BIT = 6;
    localparam int IOC_B_INV_BIT = 5;
    localparam int IOC_A_INV_BIT = 4;
    localparam int STAT_INIT_BIT = 0;
    localparam int STAT_HOME_BIT = 1;
    localparam int STAT_IDX_BIT = 2;

    // ****************************************
    // reset values and write masks
    // ****************************************
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'hbf7f;
    localparam logic [8:0] IOC_RST = 9'h000;
    localparam logic [8:0] IOC_WMASK = 9'h1f0;
    localparam logic [2:0] STAT_RST = 3'h0;
    localparam logic [31:0] REG32_RST = 32'h0000_0000;

    // ****************************************
    // mode encodings
    // ****************************************
    typedef enum logic [2:0] {
        PIM_NONE = 3'b000,
        PIM_EVERY_IDX = 3'b001,
        PIM_NEXT_IDX = 3'b010,
        PIM_FIRST_HOME = 3'b011,
        PIM_SECOND_HOME = 3'b100,
        PIM_GE_RESET = 3'b101,
        PIM_MODULO = 3'b110,
        PIM_RSVD = 3'b111
    } qpic_pim_t;

    typedef enum logic [1:0] {
        CCM_QUAD = 2'b00,
        CCM_UPDN = 2'b01,
        CCM_EXTCLK = 2'b10,
        CCM_TIMER = 2'b11
    } qpic_ccm_t;

endpackage

// ==== hdl/qpic_top.sv ====
/*
 * encoder interface position counter with initialization control, index
 * counter, shared init/compare high register and compare low register,
 * all behind an apb slave.
 * assumes encoder pins are already synchronous to pclk and one clock domain.
 */
// The APB interface to the registers and the register addresses were left to the implementer.
// Notes on behaviour
// - init mode field sits in control bits 12..10; code 111 reserved, acts as none.
// - init mode 110 wraps position counter between low and high bounds.
// - init mode 101 clears position counter when it equals the high compare.
// - init mode 100 loads init value on second index after home.
// - init mode 011 loads init value on first index after home.
// - init mode 010 loads init value on the next index only.
// - control bits 9 and 8 give phase b and phase a index match levels.
// - counter modes 10 and 11 make all counters timers, init mode ignored.
// - index match uses phases after swap and polarity inversion.
// - a 32-bit counter counts index pulses.
// - 32-bit compare low register plus shared 32-bit init/compare high register.
// - quadrature, up/down, gated count, gated timer and internal timer modes.
// - counter mode 00 is x4 quadrature; in init mode 001 a matched index resets the counter.
`timescale 1ns/1ps

module qpic_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic phase_a_input,
    input wire logic phase_b_input,
    input wire logic index_input,
    input wire logic home_input,
    input wire logic cpu_idle,
    output logic init_done
);

    // ****************************************
    // state
    // ****************************************
    logic [15:0] encoder_control_r;
    logic [8:0] io_control_r;
    logic [31:0] position_counter_r;
    logic [31:0] index_count_r;
    logic [31:0] high_cmp_r;
    logic [31:0] low_cmp_r;
    logic [2:0] status_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic a_prev_r;
    logic b_prev_r;
    logic idx_prev_r;
    logic home_prev_r;
    logic [7:0] presc_r;
    logic arm_next_r;
    logic home_seen_r;
    logic idx_after_home_r;

    logic [31:0] position_counter_nxt;
    logic [31:0] rd_val;
    logic step;
    logic up;
    logic up_raw;
    logic init_load;
    logic rd_hit;

    function automatic logic [7:0] div_limit(input logic [2:0] sel);
        div_limit = (8'h01 << sel) - 8'h01;
    endfunction

    // ****************************************
    // decode of control and pins
    // ****************************************
    qpic_pkg::qpic_pim_t pim;
    qpic_pkg::qpic_ccm_t counter_mode_select;
    logic module_counter_enable;
    logic run;
    logic timer_mode;
    logic a_eff;
    logic b_eff;
    logic idx_eff;
    logic home_eff;
    logic idx_evt;
    logic home_evt;
    logic idx_match;
    logic idx_q;
    logic tick;
    logic gate_ok;

    assign pim = qpic_pkg::qpic_pim_t'(encoder_control_r[qpic_pkg::CTRL_PIM_LSB +: 3]);
    assign counter_mode_select = qpic_pkg::qpic_ccm_t'(encoder_control_r[qpic_pkg::CTRL_CCM_LSB +: 2]);
    assign module_counter_enable = encoder_control_r[qpic_pkg::CTRL_EN_BIT];
    // idle hold only matters when software asked for it
    assign run = module_counter_enable
        & ~(encoder_control_r[qpic_pkg::CTRL_IDLE_BIT] & cpu_idle);
    assign timer_mode = counter_mode_select[1];

    // swap first, then per-input inversion
    assign a_eff = (io_control_r[qpic_pkg::IOC_SWAP_BIT] ? phase_b_input : phase_a_input)
        ^ io_control_r[qpic_pkg::IOC_A_INV_BIT];
    assign b_eff = (io_control_r[qpic_pkg::IOC_SWAP_BIT] ? phase_a_input : phase_b_input)
        ^ io_control_r[qpic_pkg::IOC_B_INV_BIT];
    assign idx_eff = index_input ^ io_control_r[qpic_pkg::IOC_IDX_INV_BIT];
    assign home_eff = home_input ^ io_control_r[qpic_pkg::IOC_HOME_INV_BIT];
    assign idx_evt = idx_eff & ~idx_prev_r;
    assign home_evt = home_eff & ~home_prev_r;
    assign idx_match = (a_eff == encoder_control_r[qpic_pkg::CTRL_IMV_LSB])
        & (b_eff == encoder_control_r[qpic_pkg::CTRL_IMV_LSB + 1]);
    // only quadrature mode qualifies index events with the phase pattern
    assign idx_q = idx_evt & ((counter_mode_select != qpic_pkg::CCM_QUAD) | idx_match);
    assign tick = presc_r == div_limit(encoder_control_r[qpic_pkg::CTRL_DIV_LSB +: 3]);
    assign gate_ok = ~encoder_control_r[qpic_pkg::CTRL_GATE_BIT] | b_eff;

    // ****************************************
    // apb decode
    // ****************************************
    logic setup;
    logic acc;
    logic wr;

    assign setup = psel & ~penable;
    assign acc = psel & penable & pready_r;
    assign wr = acc & pwrite;

    // ****************************************
    // count step per counter mode
    // ****************************************
    always_comb begin
        step = 1'b0;
        up_raw = 1'b1;
        unique case (counter_mode_select)
            qpic_pkg::CCM_QUAD: begin
                // exactly one phase changed; direction from new a against old b
                step = (a_eff ^ a_prev_r) != (b_eff ^ b_prev_r);
                up_raw = a_eff ^ b_prev_r;
            end
            qpic_pkg::CCM_UPDN: begin
                step = a_eff & ~a_prev_r;
                up_raw = b_eff;
            end
            qpic_pkg::CCM_EXTCLK: begin
                step = a_eff & ~a_prev_r & gate_ok;
            end
            qpic_pkg::CCM_TIMER: begin
                step = tick & gate_ok;
            end
        endcase
        up = up_raw ^ encoder_control_r[qpic_pkg::CTRL_POL_BIT];
    end

    // ****************************************
    // next position value
    // ****************************************
    always_comb begin
        logic [31:0] counted;
        counted = step ? (up ? position_counter_r + 32'h1 : position_counter_r - 32'h1)
            : position_counter_r;
        position_counter_nxt = position_counter_r;
        init_load = 1'b0;
        if (run) begin
            position_counter_nxt = counted;
            if (!timer_mode) begin
                unique case (pim)
                    qpic_pkg::PIM_MODULO: begin
                        if (step && up && position_counter_r == high_cmp_r) begin
                            position_counter_nxt = low_cmp_r;
                        end else if (step && !up && position_counter_r == low_cmp_r) begin
                            position_counter_nxt = high_cmp_r;
                        end
                    end
                    qpic_pkg::PIM_GE_RESET: begin
                        if (position_counter_r == high_cmp_r) begin
                            position_counter_nxt = qpic_pkg::REG32_RST;
                        end
                    end
                    qpic_pkg::PIM_EVERY_IDX: begin
                        if (idx_q) begin
                            position_counter_nxt = qpic_pkg::REG32_RST;
                        end
                    end
                    qpic_pkg::PIM_NEXT_IDX: begin
                        init_load = idx_q & arm_next_r;
                    end
                    qpic_pkg::PIM_FIRST_HOME: begin
                        init_load = idx_q & home_seen_r & ~idx_after_home_r;
                    end
                    qpic_pkg::PIM_SECOND_HOME: begin
                        init_load = idx_q & home_seen_r & idx_after_home_r;
                    end
                    qpic_pkg::PIM_NONE, qpic_pkg::PIM_RSVD: begin
                        position_counter_nxt = counted;
                    end
                endcase
                if (init_load) begin
                    position_counter_nxt = high_cmp_r;
                end
            end
        end
    end

    // ****************************************
    // registers written by software
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            encoder_control_r <= qpic_pkg::CTRL_RST;
            io_control_r <= qpic_pkg::IOC_RST;
            high_cmp_r <= qpic_pkg::REG32_RST;
            low_cmp_r <= qpic_pkg::REG32_RST;
        end else if (ce && wr) begin
            if (paddr == qpic_pkg::OFS_CTRL) begin
                encoder_control_r <= pwdata[15:0] & qpic_pkg::CTRL_WMASK;
            end
            if (paddr == qpic_pkg::OFS_IOC) begin
                io_control_r <= pwdata[8:0] & qpic_pkg::IOC_WMASK;
            end
            if (paddr == qpic_pkg::OFS_HIGH) begin
                high_cmp_r <= pwdata;
            end
            if (paddr == qpic_pkg::OFS_LOW) begin
                low_cmp_r <= pwdata;
            end
        end
    end

    // ****************************************
    // counters
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position_counter_r <= qpic_pkg::REG32_RST;
        end else if (ce) begin
            // a software write beats any hardware update in the same cycle
            if (wr && paddr == qpic_pkg::OFS_POS) begin
                position_counter_r <= pwdata;
            end else begin
                position_counter_r <= position_counter_nxt;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_count_r <= qpic_pkg::REG32_RST;
        end else if (ce) begin
            if (wr && paddr == qpic_pkg::OFS_IDXCNT) begin
                index_count_r <= pwdata;
            end else if (run && (timer_mode ? step : idx_evt)) begin
                index_count_r <= index_count_r + 32'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_r <= 8'h00;
        end else if (ce && run) begin
            presc_r <= tick ? 8'h00 : presc_r + 8'h01;
        end
    end

    // ****************************************
    // homing sequence
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_next_r <= 1'b0;
            home_seen_r <= 1'b0;
            idx_after_home_r <= 1'b0;
        end else if (ce) begin
            if (wr && paddr == qpic_pkg::OFS_CTRL) begin
                arm_next_r <= pwdata[qpic_pkg::CTRL_PIM_LSB +: 3] == qpic_pkg::PIM_NEXT_IDX;
            end else if (init_load && pim == qpic_pkg::PIM_NEXT_IDX) begin
                arm_next_r <= 1'b0;
            end
            if (run && !timer_mode) begin
                if (home_evt) begin
                    home_seen_r <= 1'b1;
                    idx_after_home_r <= 1'b0;
                end else if (init_load) begin
                    home_seen_r <= 1'b0;
                    idx_after_home_r <= 1'b0;
                end else if (idx_q && home_seen_r && pim == qpic_pkg::PIM_SECOND_HOME) begin
                    idx_after_home_r <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // status, write one to clear, set wins
    // ****************************************
    logic [2:0] stat_set;
    logic [2:0] stat_clr;

    assign stat_set = {run & idx_evt, run & home_evt, init_load};
    assign stat_clr = (wr && paddr == qpic_pkg::OFS_STAT) ? pwdata[2:0] : 3'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= qpic_pkg::STAT_RST;
        end else if (ce) begin
            status_r <= (status_r & ~stat_clr) | stat_set;
        end
    end

    // ****************************************
    // apb read and answer
    // ****************************************
    always_comb begin
        rd_val = qpic_pkg::REG32_RST;
        rd_hit = 1'b1;
        unique case (paddr)
            qpic_pkg::OFS_CTRL: rd_val = {16'h0000, encoder_control_r};
            qpic_pkg::OFS_IOC: rd_val = {23'h0, io_control_r[8:4], home_eff, idx_eff, b_eff, a_eff};
            qpic_pkg::OFS_POS: rd_val = position_counter_r;
            qpic_pkg::OFS_IDXCNT: rd_val = index_count_r;
            qpic_pkg::OFS_HIGH: rd_val = high_cmp_r;
            qpic_pkg::OFS_LOW: rd_val = low_cmp_r;
            qpic_pkg::OFS_STAT: rd_val = {29'h0, status_r};
            default: rd_hit = 1'b0;
        endcase
    end

    // answer one cycle after setup: zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= qpic_pkg::REG32_RST;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            a_prev_r <= 1'b0;
            b_prev_r <= 1'b0;
            idx_prev_r <= 1'b0;
            home_prev_r <= 1'b0;
        end else if (ce) begin
            pready_r <= setup & ~pready_r;
            pslverr_r <= setup & ~rd_hit;
            if (setup) begin
                prdata_r <= rd_val;
            end
            a_prev_r <= a_eff;
            b_prev_r <= b_eff;
            idx_prev_r <= idx_eff;
            home_prev_r <= home_eff;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign init_done = status_r[qpic_pkg::STAT_INIT_BIT];

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic pos_wr;
    assign pos_wr = wr && paddr == qpic_pkg::OFS_POS;

    chk_modulo_wrap: assert property (
        ce && run && !timer_mode && pim == qpic_pkg::PIM_MODULO && step && up && !pos_wr
        && position_counter_r == high_cmp_r |=> position_counter_r == $past(low_cmp_r))
        else $error("modulo mode did not wrap to low bound");
    chk_ge_reset: assert property (
        ce && run && !timer_mode && pim == qpic_pkg::PIM_GE_RESET && !pos_wr
        && position_counter_r == high_cmp_r |=> position_counter_r == 32'h0)
        else $error("position not cleared at high compare");
    chk_first_after_home: assert property (
        ce && run && !timer_mode && pim == qpic_pkg::PIM_FIRST_HOME && home_seen_r
        && !idx_after_home_r && idx_q && !pos_wr |=> position_counter_r == $past(high_cmp_r)
        && init_done)
        else $error("first index after home did not load");
    chk_next_index_once: assert property (
        ce && run && !timer_mode && pim == qpic_pkg::PIM_NEXT_IDX && arm_next_r && idx_q
        && !pos_wr && !wr |=> !arm_next_r && position_counter_r == $past(high_cmp_r))
        else $error("next index load missing or not disarmed");
    chk_timer_no_init: assert property (
        timer_mode |-> !init_load)
        else $error("init load taken in timer mode");
    chk_index_count: assert property (
        ce && run && !timer_mode && idx_evt && !(wr && paddr == qpic_pkg::OFS_IDXCNT)
        |=> index_count_r == $past(index_count_r) + 32'h1)
        else $error("index pulse not counted");
    chk_match_reset: assert property (
        ce && run && counter_mode_select == qpic_pkg::CCM_QUAD && pim == qpic_pkg::PIM_EVERY_IDX && idx_evt
        && idx_match && !pos_wr |=> position_counter_r == 32'h0)
        else $error("matched index did not reset position");
    chk_disabled_hold: assert property (
        !module_counter_enable && !wr |=> $stable(position_counter_r) && $stable(index_count_r))
        else $error("counters moved while disabled");
    chk_none_ignores_idx: assert property (
        ce && run && !timer_mode && pim == qpic_pkg::PIM_NONE && idx_evt && !step && !pos_wr
        |=> $stable(position_counter_r))
        else $error("index disturbed position in mode none");

    cov_init_load: cover property (ce && init_load ##1 init_done);
    cov_modulo_wrap: cover property (ce && run && pim == qpic_pkg::PIM_MODULO && step
        && position_counter_r == high_cmp_r);
    cov_timer_count: cover property (ce && run && counter_mode_select == qpic_pkg::CCM_TIMER && step);
    cov_bus_error: cover property (pslverr_r && pready_r);

endmodule

// ==== testbench/qpic_encoder_model.sv ====
/* behavioural incremental encoder with gray-coded phases, index and home.
   assumes step, index and home requests are one-cycle pulses on pclk. */
`timescale 1ns/1ps

module qpic_encoder_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic step_req,
    input wire logic index_req,
    input wire logic home_req,
    output logic phase_a,
    output logic phase_b,
    output logic index_out,
    output logic home_out
);
    // ****************************************
    // phase generator
    // ****************************************
    logic [1:0] pos_r;

    // one phase change per cycle with step_req high, so requests in adjacent cycles give two adjacent changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_r <= 2'h0;
            index_out <= 1'b0;
            home_out <= 1'b0;
        end else begin
            if (step_req) begin
                pos_r <= pos_r + 2'h1;
            end
            index_out <= index_req;
            home_out <= home_req;
        end
    end

    assign phase_a = pos_r[0] ^ pos_r[1];
    assign phase_b = pos_r[1];
endmodule

// ==== testbench/quadrature_position_init_control_bench.sv ====
/* self-checking bench for the encoder position init control block.
   assumes an apb slave that answers with pready; ce drops once, to freeze the timer. */
`timescale 1ns/1ps

module quadrature_position_init_control_bench;
    // ****************************************
    // signals and instances
    // ****************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic init_done;
    logic step_req = 1'b0;
    logic index_req = 1'b0;
    logic home_req = 1'b0;
    logic pa;
    logic pb;
    logic ix;
    logic hm;
    logic [31:0] rd;
    logic err;
    int bad_count = 0;
    int comparisons = 0;

    always #50 pclk = ~pclk;

    qpic_top uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phase_a_input(pa), .phase_b_input(pb), .index_input(ix),
        .home_input(hm), .cpu_idle(1'b0), .init_done(init_done));

    qpic_encoder_model enc (.pclk(pclk), .presetn(presetn), .step_req(step_req),
        .index_req(index_req), .home_req(home_req), .phase_a(pa), .phase_b(pb),
        .index_out(ix), .home_out(hm));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask

    // enable, init mode, match pattern and counter mode, then clear position
    task automatic cfg(input logic [2:0] m, input logic [1:0] p, input logic [1:0] c);
        apb(1'b1, qpic_pkg::OFS_CTRL, {16'h0, 1'b1, 2'b00, m, p, 6'h00, c});
        apb(1'b1, qpic_pkg::OFS_POS, 32'h0);
    endtask

    task automatic steps(input int n);
        repeat (n) begin
            @(posedge pclk);
            step_req <= 1'b1;
            @(posedge pclk);
            step_req <= 1'b0;
        end
        repeat (3) @(posedge pclk);
    endtask

    task automatic pulse(input logic home);
        @(posedge pclk);
        if (home) home_req <= 1'b1;
        else index_req <= 1'b1;
        @(posedge pclk);
        home_req <= 1'b0;
        index_req <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        rchk("ctrl reset", qpic_pkg::OFS_CTRL, 32'h0);
        chk("init_done reset", 32'h0, {31'h0, init_done});
        apb(1'b1, qpic_pkg::OFS_CTRL, 32'h0000_7fff);
        rchk("ctrl mask", qpic_pkg::OFS_CTRL, {16'h0, qpic_pkg::CTRL_WMASK & 16'h7fff});
        apb(1'b1, qpic_pkg::OFS_POS, 32'h1234_5678);
        steps(4);
        rchk("pos held", qpic_pkg::OFS_POS, 32'h1234_5678);
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        $display("test regs done");
    endtask

    task automatic t_quad();
        cfg(3'b001, 2'b00, 2'b00);
        steps(5);
        rchk("x4 count", qpic_pkg::OFS_POS, 32'h5);
        pulse(1'b0);
        rchk("no match", qpic_pkg::OFS_POS, 32'h5);
        steps(3);
        pulse(1'b0);
        rchk("index reset", qpic_pkg::OFS_POS, 32'h0);
        rchk("index count", qpic_pkg::OFS_IDXCNT, 32'h2);
        cfg(3'b001, 2'b01, 2'b00);
        steps(1);
        pulse(1'b0);
        rchk("match a high", qpic_pkg::OFS_POS, 32'h0);
        steps(3);
        apb(1'b1, qpic_pkg::OFS_IOC, 32'h010);
        rchk("ioc a inv", qpic_pkg::OFS_IOC, 32'h011);
        pulse(1'b0);
        rchk("inv match", qpic_pkg::OFS_POS, 32'h0);
        apb(1'b1, qpic_pkg::OFS_IOC, 32'h000);
        cfg(3'b001, 2'b10, 2'b00);
        steps(3);
        pulse(1'b0);
        rchk("match b high", qpic_pkg::OFS_POS, 32'h0);
        steps(1);
        $display("test quad done");
    endtask

    task automatic t_init();
        apb(1'b1, qpic_pkg::OFS_HIGH, 32'h55);
        cfg(3'b010, 2'b00, 2'b00);
        pulse(1'b0);
        rchk("next index", qpic_pkg::OFS_POS, 32'h55);
        chk("init_done", 32'h1, {31'h0, init_done});
        rchk("status", qpic_pkg::OFS_STAT, 32'h5);
        apb(1'b1, qpic_pkg::OFS_STAT, 32'h7);
        rchk("status clear", qpic_pkg::OFS_STAT, 32'h0);
        steps(4);
        pulse(1'b0);
        rchk("one load", qpic_pkg::OFS_POS, 32'h59);
        steps(4);
        cfg(3'b011, 2'b00, 2'b00);
        pulse(1'b0);
        rchk("no home", qpic_pkg::OFS_POS, 32'h0);
        pulse(1'b1);
        pulse(1'b0);
        rchk("first after home", qpic_pkg::OFS_POS, 32'h55);
        cfg(3'b100, 2'b00, 2'b00);
        pulse(1'b1);
        pulse(1'b0);
        rchk("one after home", qpic_pkg::OFS_POS, 32'h0);
        pulse(1'b0);
        rchk("second after home", qpic_pkg::OFS_POS, 32'h55);
        $display("test init done");
    endtask

    task automatic t_bounds();
        apb(1'b1, qpic_pkg::OFS_HIGH, 32'h3);
        cfg(3'b101, 2'b00, 2'b00);
        steps(3);
        rchk("ge reset", qpic_pkg::OFS_POS, 32'h0);
        steps(1);
        apb(1'b1, qpic_pkg::OFS_LOW, 32'h0);
        cfg(3'b110, 2'b00, 2'b00);
        steps(6);
        rchk("modulo wrap", qpic_pkg::OFS_POS, 32'h2);
        steps(2);
        cfg(3'b001, 2'b00, 2'b10);
        steps(4);
        pulse(1'b0);
        rchk("timer ignores init", qpic_pkg::OFS_POS, 32'h1);
        cfg(3'b000, 2'b00, 2'b01);
        steps(1);
        pulse(1'b0);
        rchk("up down", qpic_pkg::OFS_POS, 32'hffff_ffff);
        cfg(3'b000, 2'b00, 2'b11);
        // ce low must freeze the free-running timer, else it would read 6
        ce <= 1'b0;
        repeat (5) @(posedge pclk);
        ce <= 1'b1;
        rchk("timer with ce hold", qpic_pkg::OFS_POS, 32'h1);
        $display("test bounds done");
    endtask

    // ****************************************
    // run control
    // ****************************************
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // whole run is well under 2000 cycles, so a hang shows long before this
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        end_of_test();
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_quad();
        t_init();
        t_bounds();
        end_of_test();
    end
endmodule
